// >>> core/tcp_channel.sv
`timescale 1ns/1ps
// one instance per channel, nothing channel-specific inside
module tcp_channel
#(
  parameter int unsigned CNT_W = 16
)
(
  input wire logic mclk_i,
  input wire logic reset_i,
  input wire logic [3:0] addr_i,
  input wire logic [31:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output logic [31:0] rdata_o,
  input wire logic [CNT_W-1:0] up_counter_i,
  input wire logic capture_a_i,
  input wire logic capture_b_i,
  output logic count_clock_div2_o,
  output logic count_clock_div8_o,
  output logic count_clock_div32_o,
  output logic match_b_o,
  output logic irq_o
);
  tcp_tick_if tk();

  logic [CNT_W-1:0] compare_value_b_q;
  logic [CNT_W-1:0] capture_value_a_q;
  logic [CNT_W-1:0] capture_value_b_q;
  logic prescaler_run_q;
  logic fpsel_q;
  logic [2:0] gear_q;
  logic [2:0] prck_q;
  logic match_b_flag_q;
  logic mask_q;
  logic match_b_q;
  logic irq_q;
  logic [31:0] rdata_q;
  logic [31:0] rdata_d;
  logic wr_cmp;
  logic wr_ctl;
  logic wr_sts;
  logic wr_msk;
  logic match_hit;
  logic match_prev_q;
  logic flag_d;
  logic [31:0] ctl_word;

  function automatic logic [31:0] zext(input logic [CNT_W-1:0] v);
    return {{(32-CNT_W){1'b0}}, v};
  endfunction

  tcp_prescaler u_pre
  (
    .mclk_i(mclk_i),
    .reset_i(reset_i),
    .tk(tk)
  );

  assign tk.run = prescaler_run_q;
  assign tk.fpsel = fpsel_q;
  assign tk.gear = gear_q;
  assign tk.prck = prck_q;

  assign wr_cmp = wr_i && (addr_i == tcp_pkg::OFS_COMPARE_B);
  assign wr_ctl = wr_i && (addr_i == tcp_pkg::OFS_CONTROL);
  assign wr_sts = wr_i && (addr_i == tcp_pkg::OFS_STATUS);
  assign wr_msk = wr_i && (addr_i == tcp_pkg::OFS_MASK);
  // rising edge of equality so a held count raises one event
  assign match_hit = (up_counter_i == compare_value_b_q) && !match_prev_q;
  // set wins over the write-one clear
  assign flag_d = match_hit | (match_b_flag_q & ~(wr_sts & wdata_i[tcp_pkg::IRQ_MATCH_BIT]));
  assign ctl_word = 32'(prescaler_run_q) << tcp_pkg::CTL_RUN_BIT
                  | 32'(fpsel_q) << tcp_pkg::CTL_FPSEL_BIT
                  | 32'(gear_q) << tcp_pkg::CTL_GEAR_LSB
                  | 32'(prck_q) << tcp_pkg::CTL_PRCK_LSB;
  // upper halves read zero; unmapped reads zero
  assign rdata_d = !rd_i ? 32'h0 :
    (addr_i == tcp_pkg::OFS_COMPARE_B) ? zext(compare_value_b_q) :
    (addr_i == tcp_pkg::OFS_CAPTURE_A) ? zext(capture_value_a_q) :
    (addr_i == tcp_pkg::OFS_CAPTURE_B) ? zext(capture_value_b_q) :
    (addr_i == tcp_pkg::OFS_CONTROL) ? ctl_word :
    (addr_i == tcp_pkg::OFS_STATUS) ? 32'(match_b_flag_q) :
    (addr_i == tcp_pkg::OFS_MASK) ? 32'(mask_q) : 32'h0;

  // capture words carry no reset: contents undefined until first strobe
  always_ff @(posedge mclk_i)
  begin
    if (capture_a_i)
      capture_value_a_q <= up_counter_i;
    if (capture_b_i)
      capture_value_b_q <= up_counter_i;
  end

  always_ff @(posedge mclk_i)
  begin
    if (reset_i)
    begin
      compare_value_b_q <= tcp_pkg::COMPARE_RESET;
      prescaler_run_q <= 1'b0;
      fpsel_q <= 1'b0;
      gear_q <= tcp_pkg::GEAR_DIV1;
      prck_q <= 3'h0;
      match_b_flag_q <= 1'b0;
      mask_q <= 1'b0;
      match_b_q <= 1'b0;
      match_prev_q <= 1'b0;
      irq_q <= 1'b0;
      rdata_q <= 32'h0;
    end
    else
    begin
      if (wr_cmp)
        compare_value_b_q <= wdata_i[CNT_W-1:0];
      if (wr_ctl)
      begin
        prescaler_run_q <= wdata_i[tcp_pkg::CTL_RUN_BIT];
        fpsel_q <= wdata_i[tcp_pkg::CTL_FPSEL_BIT];
        gear_q <= wdata_i[tcp_pkg::CTL_GEAR_LSB +: 3];
        prck_q <= wdata_i[tcp_pkg::CTL_PRCK_LSB +: 3];
      end
      if (wr_msk)
        mask_q <= wdata_i[tcp_pkg::IRQ_MATCH_BIT];
      match_prev_q <= (up_counter_i == compare_value_b_q);
      match_b_flag_q <= flag_d;
      match_b_q <= match_hit;
      irq_q <= flag_d & (wr_msk ? wdata_i[tcp_pkg::IRQ_MATCH_BIT] : mask_q);
      rdata_q <= rdata_d;
    end
  end

  assign rdata_o = rdata_q;
  assign match_b_o = match_b_q;
  assign irq_o = irq_q;
  assign count_clock_div2_o = tk.tick_div2;
  assign count_clock_div8_o = tk.tick_div8;
  assign count_clock_div32_o = tk.tick_div32;

  a_flag_on_match: assert property (@(posedge mclk_i) disable iff (reset_i)
    match_hit |=> match_b_flag_q)
    else $error("match did not set flag");
  a_cmp_write: assert property (@(posedge mclk_i) disable iff (reset_i)
    wr_cmp |=> compare_value_b_q == $past(wdata_i[CNT_W-1:0]))
    else $error("compare write lost");
  a_cap_a_load: assert property (@(posedge mclk_i) disable iff (reset_i)
    capture_a_i |=> capture_value_a_q == $past(up_counter_i))
    else $error("capture a wrong");
  a_cap_b_hold: assert property (@(posedge mclk_i) disable iff (reset_i)
    !capture_b_i |=> $stable(capture_value_b_q))
    else $error("capture b moved");
  a_read_upper_zero: assert property (@(posedge mclk_i) disable iff (reset_i)
    rd_i && addr_i != tcp_pkg::OFS_CONTROL |=> rdata_o[31:16] == 16'h0)
    else $error("upper bits nonzero");
  a_stop_silent: assert property (@(posedge mclk_i) disable iff (reset_i)
    !prescaler_run_q ##1 !prescaler_run_q |-> !count_clock_div2_o && !count_clock_div32_o)
    else $error("tick while stopped");
  a_irq_masked: assert property (@(posedge mclk_i) disable iff (reset_i)
    irq_o |-> match_b_flag_q)
    else $error("irq without flag");
  a_div32_sparse: assert property (@(posedge mclk_i) disable iff (reset_i)
    count_clock_div32_o |=> !count_clock_div32_o [*8])
    else $error("div32 too fast");
  a_div2_sparse: assert property (@(posedge mclk_i) disable iff (reset_i)
    count_clock_div2_o |=> !count_clock_div2_o)
    else $error("div2 too fast");
endmodule

// >>> common/tcp_pkg.sv
// Operation
// - compare_value_b is a 16-bit read/write word, upper bits zero, reset zero.
// - two read-only 16-bit capture words, contents undefined after reset, upper bits zero.
// - a 4-bit prescaler supplies the selectable up-counter source ticks.
// - prescaler input is peripheral clock divided 1..32, codes 000..101 ascending.
// - peripheral select 0 takes geared clock, 1 takes undivided oscillator clock.
// - geared clock is oscillator clock over 1,2,4,8 by gear codes 000,100,101,110.
// - run bit one starts prescaler; zero clears and stops it.
// - prescaler gives divide-by-2, divide-by-8 and divide-by-32 count ticks.
// - every channel instance behaves identically; only parameters may differ.
// - up-counter equal to compare_value_b sets match_b_flag even when masked.
package tcp_pkg;
  localparam int unsigned ADDR_W = 4;
  localparam logic [3:0] OFS_COMPARE_B = 4'h0;
  localparam logic [3:0] OFS_CAPTURE_A = 4'h4;
  localparam logic [3:0] OFS_CAPTURE_B = 4'h8;
  localparam logic [3:0] OFS_CONTROL = 4'hc;
  localparam logic [3:0] OFS_STATUS = 4'h1;
  localparam logic [3:0] OFS_MASK = 4'h2;
  localparam int unsigned CTL_RUN_BIT = 0;
  localparam int unsigned CTL_FPSEL_BIT = 1;
  localparam int unsigned CTL_GEAR_LSB = 4;
  localparam int unsigned CTL_PRCK_LSB = 8;
  localparam logic [15:0] COMPARE_RESET = 16'h0000;
  localparam logic [2:0] GEAR_DIV1 = 3'h0;
  localparam logic [2:0] GEAR_DIV2 = 3'h4;
  localparam logic [2:0] GEAR_DIV4 = 3'h5;
  localparam logic [2:0] GEAR_DIV8 = 3'h6;
  localparam int unsigned IRQ_MATCH_BIT = 0;
  localparam int unsigned TAP_DIV2 = 0;
  localparam int unsigned TAP_DIV8 = 2;
  localparam int unsigned TAP_DIV32 = 4;
endpackage

// >>> common/tcp_tick_if.sv
`timescale 1ns/1ps
interface tcp_tick_if;
  logic run;
  logic fpsel;
  logic [2:0] gear;
  logic [2:0] prck;
  logic tick_div2;
  logic tick_div8;
  logic tick_div32;
  modport src (input run, fpsel, gear, prck, output tick_div2, tick_div8, tick_div32);
  modport ctl (output run, fpsel, gear, prck, input tick_div2, tick_div8, tick_div32);
endinterface

// >>> core/tcp_prescaler.sv
`timescale 1ns/1ps
// mclk_i stands for the oscillator clock; all dividers are tick enables on it
module tcp_prescaler
(
  input wire logic mclk_i,
  input wire logic reset_i,
  tcp_tick_if.src tk
);
  logic [2:0] osc_cnt_q;
  logic [2:0] osc_cnt_d;
  logic gear_tick;
  logic [4:0] per_cnt_q;
  logic [4:0] per_cnt_d;
  logic periph_tick;
  logic [5:0] pre_ext;
  logic input_tick;
  logic [3:0] pre_q;
  logic [3:0] pre_d;
  logic [3:0] pre_toggle;
  logic carry_q;
  logic carry_d;
  logic t2_q;
  logic t8_q;
  logic t32_q;

  // tick every 2^n enabled cycles: all low bits at one
  function automatic logic every_pow2(input logic [5:0] cnt, input logic [2:0] n);
    logic [5:0] m;
    m = 6'((7'h1 << n) - 7'h1);
    return (cnt & m) == m;
  endfunction

  assign osc_cnt_d = osc_cnt_q + 3'h1;
  assign gear_tick = (tk.gear == tcp_pkg::GEAR_DIV2) ? every_pow2({3'h0, osc_cnt_q}, 3'h1) :
                     (tk.gear == tcp_pkg::GEAR_DIV4) ? every_pow2({3'h0, osc_cnt_q}, 3'h2) :
                     (tk.gear == tcp_pkg::GEAR_DIV8) ? every_pow2({3'h0, osc_cnt_q}, 3'h3) :
                     1'b1;
  assign periph_tick = tk.fpsel ? 1'b1 : gear_tick;
  assign per_cnt_d = periph_tick ? per_cnt_q + 5'h1 : per_cnt_q;
  // codes above 101 clamp to /32
  assign input_tick = periph_tick &
    every_pow2({1'b0, per_cnt_q}, (tk.prck > 3'h5) ? 3'h5 : tk.prck);
  // carry bit extends the 4-bit prescaler so the slowest tap reaches /32
  assign pre_ext = {1'b0, carry_q, pre_q};
  assign pre_toggle = pre_q + 4'h1;
  assign pre_d = !tk.run ? 4'h0 : (input_tick ? pre_toggle : pre_q);
  assign carry_d = !tk.run ? 1'b0 : (carry_q ^ (input_tick & (pre_q == 4'hf)));

  always_ff @(posedge mclk_i)
  begin
    if (reset_i)
    begin
      osc_cnt_q <= 3'h0;
      per_cnt_q <= 5'h0;
      pre_q <= 4'h0;
      carry_q <= 1'b0;
      t2_q <= 1'b0;
      t8_q <= 1'b0;
      t32_q <= 1'b0;
    end
    else
    begin
      osc_cnt_q <= osc_cnt_d;
      per_cnt_q <= per_cnt_d;
      pre_q <= pre_d;
      carry_q <= carry_d;
      // a tap fires when all bits up to and including its own are one
      t2_q <= tk.run & input_tick & every_pow2(pre_ext, 3'(tcp_pkg::TAP_DIV2 + 1));
      t8_q <= tk.run & input_tick & every_pow2(pre_ext, 3'(tcp_pkg::TAP_DIV8 + 1));
      t32_q <= tk.run & input_tick & every_pow2(pre_ext, 3'(tcp_pkg::TAP_DIV32 + 1));
    end
  end

  assign tk.tick_div2 = t2_q;
  assign tk.tick_div8 = t8_q;
  assign tk.tick_div32 = t32_q;
endmodule

// >>> bench/tcp_channel_tb_top.sv
`timescale 1ns/1ps
module tcp_channel_tb_top;
  logic mclk_i = 1'b0;
  logic reset_i = 1'b1;
  logic [3:0] addr_i = 4'h0;
  logic [31:0] wdata_i = 32'h0;
  logic wr_i = 1'b0;
  logic rd_i = 1'b0;
  logic [31:0] rdata_o;
  logic [15:0] up_counter_i = 16'h0;
  logic capture_a_i = 1'b0;
  logic capture_b_i = 1'b0;
  logic div2_o;
  logic div8_o;
  logic div32_o;
  logic match_b_o;
  logic irq_o;
  logic [2:0] gears [4] = '{tcp_pkg::GEAR_DIV1, tcp_pkg::GEAR_DIV2, tcp_pkg::GEAR_DIV4,
    tcp_pkg::GEAR_DIV8};
  int mismatches = 0;
  int tests_run = 0;
  int n2;
  int n8;
  int n32;
  tcp_channel tcp_channel_i (.mclk_i(mclk_i), .reset_i(reset_i), .addr_i(addr_i),
    .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
    .up_counter_i(up_counter_i), .capture_a_i(capture_a_i), .capture_b_i(capture_b_i),
    .count_clock_div2_o(div2_o), .count_clock_div8_o(div8_o),
    .count_clock_div32_o(div32_o), .match_b_o(match_b_o), .irq_o(irq_o));
  initial
  begin
    forever #10 mclk_i = ~mclk_i;
  end
  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp)
    begin
      mismatches++;
      $display("mismatch %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge mclk_i);
    wr_i <= 1'b1;
    addr_i <= a;
    wdata_i <= d;
    @(posedge mclk_i);
    wr_i <= 1'b0;
  endtask
  // read data stand only in the cycle after the strobe
  task automatic rd(input string name, input logic [3:0] a, input logic [31:0] exp);
    @(posedge mclk_i);
    rd_i <= 1'b1;
    addr_i <= a;
    @(posedge mclk_i);
    rd_i <= 1'b0;
    #1;
    check(name, rdata_o, exp);
  endtask
  // windows are multiples of every checked tick period, so phase does not matter
  task automatic count(input int n);
    n2 = 0;
    n8 = 0;
    n32 = 0;
    repeat (n)
    begin
      @(posedge mclk_i);
      n2 += int'(div2_o === 1'b1);
      n8 += int'(div8_o === 1'b1);
      n32 += int'(div32_o === 1'b1);
    end
  endtask
  task automatic set_ctl(input logic run, input logic fp, input logic [2:0] g,
    input logic [2:0] p);
    logic [31:0] c;
    c = 32'h0;
    c[tcp_pkg::CTL_RUN_BIT] = run;
    c[tcp_pkg::CTL_FPSEL_BIT] = fp;
    c[tcp_pkg::CTL_GEAR_LSB +: 3] = g;
    c[tcp_pkg::CTL_PRCK_LSB +: 3] = p;
    wr(tcp_pkg::OFS_CONTROL, c);
    repeat (64) @(posedge mclk_i);
    count(256);
  endtask
  task automatic hit(input logic [15:0] v);
    @(posedge mclk_i);
    up_counter_i <= v - 16'h1;
    @(posedge mclk_i);
    up_counter_i <= v;
    @(posedge mclk_i);
    #1;
  endtask
  task automatic end_of_test;
    $display("comparisons %0d mismatches %0d", tests_run, mismatches);
    if (mismatches == 0 && tests_run > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  initial
  begin
    #400000;
    mismatches++;
    end_of_test();
  end
  initial
  begin
    repeat (16) @(posedge mclk_i);
    reset_i <= 1'b0;
    rd("compare_reset", tcp_pkg::OFS_COMPARE_B, 32'h0);
    rd("unmapped", 4'h3, 32'h0);
    wr(tcp_pkg::OFS_COMPARE_B, 32'hffff_abcd);
    rd("compare_rw", tcp_pkg::OFS_COMPARE_B, 32'h0000_abcd);
    @(posedge mclk_i);
    up_counter_i <= 16'h1234;
    capture_a_i <= 1'b1;
    @(posedge mclk_i);
    capture_a_i <= 1'b0;
    capture_b_i <= 1'b1;
    up_counter_i <= 16'h5678;
    @(posedge mclk_i);
    capture_b_i <= 1'b0;
    up_counter_i <= 16'h9abc;
    wr(tcp_pkg::OFS_CAPTURE_A, 32'hffff_ffff);
    rd("capture_a", tcp_pkg::OFS_CAPTURE_A, 32'h0000_1234);
    rd("capture_b", tcp_pkg::OFS_CAPTURE_B, 32'h0000_5678);
    wr(tcp_pkg::OFS_COMPARE_B, 32'h0000_0040);
    wr(tcp_pkg::OFS_MASK, 32'h1);
    hit(16'h0040);
    check("match_pulse", {31'h0, match_b_o}, 32'h1);
    @(posedge mclk_i);
    #1;
    check("match_single", {31'h0, match_b_o}, 32'h0);
    check("irq_set", {31'h0, irq_o}, 32'h1);
    rd("status_set", tcp_pkg::OFS_STATUS, 32'h1);
    wr(tcp_pkg::OFS_STATUS, 32'h1);
    rd("status_clear", tcp_pkg::OFS_STATUS, 32'h0);
    check("irq_clear", {31'h0, irq_o}, 32'h0);
    wr(tcp_pkg::OFS_MASK, 32'h0);
    hit(16'h0040);
    rd("status_masked", tcp_pkg::OFS_STATUS, 32'h1);
    check("irq_masked", {31'h0, irq_o}, 32'h0);
    set_ctl(1'b1, 1'b1, tcp_pkg::GEAR_DIV1, 3'h0);
    check("div2_base", 32'(n2), 32'd128);
    check("div8_base", 32'(n8), 32'd32);
    check("div32_base", 32'(n32), 32'd8);
    for (int p = 0; p < 6; p++)
    begin
      set_ctl(1'b1, 1'b1, tcp_pkg::GEAR_DIV1, 3'(p));
      check("div2_prck", 32'(n2), 32'd128 >> p);
    end
    for (int i = 0; i < 4; i++)
    begin
      set_ctl(1'b1, 1'b0, gears[i], 3'h0);
      check("div2_gear", 32'(n2), 32'd128 >> i);
    end
    set_ctl(1'b1, 1'b1, tcp_pkg::GEAR_DIV8, 3'h0);
    check("div2_osc", 32'(n2), 32'd128);
    set_ctl(1'b0, 1'b1, tcp_pkg::GEAR_DIV1, 3'h0);
    check("ticks_stopped", 32'(n2 + n8 + n32), 32'd0);
    set_ctl(1'b1, 1'b1, tcp_pkg::GEAR_DIV1, 3'h0);
    check("div32_restart", 32'(n32), 32'd8);
    end_of_test();
  end
endmodule
